// >>> design/iae_execute.sv
// iae_execute: single-cycle integer execute datapath with trap requests.
// assumes the register file supplies operands and consumes the registered
// result one cycle after a valid issue.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - every listed operation completes in one cycle
// - eight-bit immediate may replace second operand
// - unimplemented opcode raises illegal opcode trap
// - emulation opcodes trap to fixed vectors, load pointers
// - arithmetic and logical ops update status flags
// - signed-checking add/sub trap on signed overflow
// - unsigned-checking add_trap_signed trap on carry out
// - unsigned-checking subtracts trap on borrow
// - carry add_trap_signed add carry; borrow subtracts use it
// - reverse subtract computes second minus first
// - hardware products low/high word, else trap
// - single-bit product steps plus a final step
// - full quotient operations trap to software
// - quotient init, step, final and remainder steps
// - value compares write boolean result
// - true is bit 31 set, false clear
// - byte compare true if any lane matches
// - failing assert traps to instruction vector
// - failing user-mode assert to low vector: protection trap
// - seven bitwise logical functions per bit
// - shift amount is five bits, 0 to 31
// - zero fill, arithmetic right replicates sign
// - funnel shift returns upper word of pair
module iae_execute #(
	parameter bit HAS_MULT = 1'b1
)(
	input  wire logic                          REF_CLK_I,
	input  wire logic                          NRST_I,
	input  wire logic                          VALID_I,
	input  wire logic [iae_pkg::OPC_W-1:0]     OPCODE_I,
	input  wire logic [iae_pkg::DATA_W-1:0]    FIRST_OPERAND_I,
	input  wire logic [iae_pkg::DATA_W-1:0]    SECOND_OPERAND_I,
	input  wire logic [iae_pkg::IMM_W-1:0]     IMM_I,
	input  wire logic                          IMM_SEL_I,
	input  wire logic [iae_pkg::VEC_W-1:0]     TRAP_VECTOR_NUMBER_I,
	input  wire logic                          USER_MODE_I,
	input  wire logic [iae_pkg::REGN_W-1:0]    FIRST_REG_NUM_I,
	input  wire logic [iae_pkg::REGN_W-1:0]    SECOND_REG_NUM_I,
	input  wire logic [iae_pkg::REGN_W-1:0]    RESULT_REG_NUM_I,
	input  wire logic                          FUNNEL_WE_I,
	input  wire logic                          QUOTIENT_WE_I,
	input  wire logic [iae_pkg::DATA_W-1:0]    SPR_DATA_I,
	output logic                               DONE_O,
	output logic [iae_pkg::DATA_W-1:0]         RESULT_REGISTER_O,
	output logic                               RESULT_WE_O,
	output logic                               TRAP_O,
	output logic [iae_pkg::VEC_W-1:0]          TRAP_VECTOR_O,
	output logic                               PTR_LOAD_O,
	output logic [iae_pkg::REGN_W-1:0]         PTR_FIRST_O,
	output logic [iae_pkg::REGN_W-1:0]         PTR_SECOND_O,
	output logic [iae_pkg::REGN_W-1:0]         PTR_RESULT_O,
	output logic [3:0]                         FLAGS_O,
	output logic [iae_pkg::SHAMT_W-1:0]        FUNNEL_SHIFT_COUNT_O,
	output logic [iae_pkg::DATA_W-1:0]         QUOTIENT_EXT_O
);
	import iae_pkg::*;

	// flag order {overflow, negative, zero, carry}
	logic [3:0]        flags_r;
	logic [4:0]        funnel_r;
	logic [31:0]       q_r, res_r;
	logic              done_r, we_r, trap_r, ptr_r;
	logic [7:0]        vec_r;
	logic [7:0]        pa_r, pb_r, pc_r;

	wire [7:0]  op = OPCODE_I;
	wire [31:0] a  = FIRST_OPERAND_I;
	wire [31:0] b  = IMM_SEL_I ? {24'h000000, IMM_I} : SECOND_OPERAND_I;
	wire        c_in = flags_r[0];

	// adder shared by add, subtract and reverse subtract
	wire        is_arith = op[ARITH_MSB:ARITH_LSB] == ARITH_GRP;
	wire [1:0]  kind  = op[KIND_MSB:KIND_LSB];
	wire        use_c = op[CARRY_BIT];
	wire [1:0]  chk   = op[CHK_MSB:CHK_LSB];
	wire        arith_ok = is_arith && kind != 2'h3 && chk != 2'h3;
	wire [31:0] ax = (kind == KIND_RSUB) ? b : a;
	wire [31:0] ay = (kind == KIND_ADD) ? b :
	                 (kind == KIND_SUB) ? ~b : ~a;
	// subtract: x + ~y + 1, or x + ~y + c, i.e. x - y - 1 + c
	wire        acin = use_c ? c_in : (kind != KIND_ADD);
	wire [32:0] asum = {1'b0, ax} + {1'b0, ay} + {32'h00000000, acin};
	wire        a_co = asum[32];
	wire        a_ov = (ax[31] == ay[31]) && (asum[31] != ax[31]);
	// a subtract with carry out clear has borrowed below zero
	wire        u_bad = (kind == KIND_ADD) ? a_co : !a_co;
	wire        range_trap = (chk == CHK_SIGNED && a_ov) ||
	                         (chk == CHK_UNSIGN && u_bad);

	// compares and asserts
	wire        c_eq  = a == b;
	wire        c_ltu = a < b;
	wire        c_lt  = $signed(a) < $signed(b);
	logic [3:0] lane_eq;
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_lane
			assign lane_eq[g] = a[8*g +: 8] == b[8*g +: 8];
		end
	endgenerate

	wire [3:0]  cnd = op[3:0];
	// bit n is the outcome of condition code n; unused codes read false
	wire [15:0] cnd_tab = {5'h00, |lane_eq, !c_ltu, !c_lt,
	                       !(c_ltu || c_eq), !(c_lt || c_eq), c_ltu || c_eq,
	                       c_lt || c_eq, c_ltu, c_lt, !c_eq, c_eq};
	wire        cnd_ok   = cnd <= CND_BYTE;
	wire        cnd_true = cnd_tab[cnd];
	wire        is_cmp = op[7:4] == CMP_GRP && cnd_ok;
	wire        is_asr = op[7:4] == ASSERT_GRP && cnd_ok && cnd != CND_BYTE;
	wire [31:0] bool_w = cnd_true ? BOOL_TRUE : BOOL_FALSE;
	// low vectors belong to the supervisor
	wire        asr_prot = USER_MODE_I &&
	                       TRAP_VECTOR_NUMBER_I <= VEC_USR_MAX;
	wire [7:0]  asr_vec  = asr_prot ? VEC_PROTECT : TRAP_VECTOR_NUMBER_I;

	// shifts; amount always taken modulo 32
	wire [4:0]  shamt = b[4:0];
	wire [63:0] fun_w = {a, b} << funnel_r;
	wire [31:0] shl_w = a << shamt;
	wire [31:0] shr_w = a >> shamt;
	wire [31:0] sra_w = $unsigned($signed(a) >>> shamt);

	// full products
	wire [63:0] prod_u = {32'h00000000, a} * {32'h00000000, b};
	wire [63:0] prod_s = $unsigned($signed({{32{a[31]}}, a}) *
	                               $signed({{32{b[31]}}, b}));

	// product step: multiplier bits shift out of the extension register
	wire        step_s  = op == OP_PSTEP_S;
	wire [32:0] pe_a    = {step_s & a[31], a};
	wire [32:0] pe_b    = {step_s & b[31], b};
	wire [32:0] p_acc   = q_r[0] ? pe_a + pe_b : pe_a;
	// final step removes the weight of a negative multiplier's sign bit
	wire [32:0] p_fin   = q_r[0] ? {a[31], a} - {b[31], b} : {a[31], a};

	// restoring quotient step: partial remainder in first operand
	wire [32:0] d_try   = {a, q_r[31]};
	wire        d_fit   = d_try >= {1'b0, b};
	wire [32:0] d_sub   = d_try - {1'b0, b};
	wire [31:0] d_rem   = d_fit ? d_sub[31:0] : d_try[31:0];

	wire        is_emu = (op >= EMU_A_LO && op <= EMU_A_HI) ||
	                     (op >= EMU_B_LO && op <= EMU_B_HI) ||
	                     op == EMU_C || op >= EMU_D_LO;
	wire [7:0]  emu_vec = op - EMU_OFFSET;

	// next-state selection for one issued operation
	logic [31:0] res_nxt, q_nxt;
	logic [3:0]  flags_nxt;
	logic        we_nxt, trap_nxt, ptr_nxt, upd_nz;
	logic [7:0]  vec_nxt;
	always_comb
	begin
		res_nxt   = res_r;
		q_nxt     = q_r;
		flags_nxt = flags_r;
		we_nxt    = 1'b1;
		trap_nxt  = 1'b0;
		ptr_nxt   = 1'b0;
		vec_nxt   = vec_r;
		upd_nz    = 1'b1;
		if (arith_ok)
		begin
			res_nxt      = asum[31:0];
			flags_nxt[3] = a_ov;
			flags_nxt[0] = a_co;
			trap_nxt     = range_trap; // result is still written
			vec_nxt      = VEC_RANGE;
		end
		else if (is_cmp)
		begin
			res_nxt = bool_w;
			upd_nz  = 1'b0;
		end
		else if (is_asr)
		begin
			we_nxt   = 1'b0;
			upd_nz   = 1'b0;
			trap_nxt = !cnd_true;
			vec_nxt  = asr_vec;
		end
		else if (is_emu)
		begin
			we_nxt   = 1'b0;
			upd_nz   = 1'b0;
			trap_nxt = 1'b1;
			ptr_nxt  = 1'b1;
			vec_nxt  = emu_vec;
		end
		else
		begin
			unique case (op)
				OP_AND:    res_nxt = a & b;
				OP_ANDC:   res_nxt = a & ~b;
				OP_NAND:   res_nxt = ~(a & b);
				OP_OR:     res_nxt = a | b;
				OP_NOR:    res_nxt = ~(a | b);
				OP_XOR:    res_nxt = a ^ b;
				OP_XNOR:   res_nxt = ~(a ^ b);
				OP_SHL:    res_nxt = shl_w;
				OP_SHR:    res_nxt = shr_w;
				OP_SHRA:   res_nxt = sra_w;
				OP_FUNNEL: res_nxt = fun_w[63:32];
				OP_PLO_U, OP_PLO_S, OP_PHI_S, OP_PHI_U:
				begin
					res_nxt = (op == OP_PLO_U) ? prod_u[31:0] :
					          (op == OP_PLO_S) ? prod_s[31:0] :
					          (op == OP_PHI_S) ? prod_s[63:32] :
					                             prod_u[63:32];
					if (!HAS_MULT)
					begin
						we_nxt   = 1'b0;
						upd_nz   = 1'b0;
						trap_nxt = 1'b1;
						vec_nxt  = VEC_PROD;
					end
				end
				OP_PSTEP_S, OP_PSTEP_U:
				begin
					res_nxt = p_acc[32:1];
					q_nxt   = {p_acc[0], q_r[31:1]};
				end
				OP_PFINAL:
				begin
					res_nxt = p_fin[32:1];
					q_nxt   = {p_fin[0], q_r[31:1]};
				end
				OP_QUO_U, OP_QUO_S:
				begin
					we_nxt   = 1'b0;
					upd_nz   = 1'b0;
					trap_nxt = 1'b1;
					vec_nxt  = VEC_QUO;
				end
				OP_QINIT:
				begin
					res_nxt = WORD_RST;
					q_nxt   = b;
				end
				OP_QSTEP, OP_QFINAL:
				begin
					res_nxt = d_rem;
					q_nxt   = {q_r[30:0], d_fit};
				end
				OP_QREM:   res_nxt = a;
				default:
				begin
					we_nxt   = 1'b0;
					upd_nz   = 1'b0;
					trap_nxt = 1'b1;
					vec_nxt  = VEC_ILLEGAL;
				end
			endcase
		end
		if (upd_nz)
			flags_nxt[2:1] = {res_nxt[31], res_nxt == WORD_RST};
	end

	// one issue per cycle, answered at the next edge
	always_ff @(posedge REF_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			{done_r, we_r, trap_r, ptr_r} <= 4'h0;
		else
			{done_r, we_r, trap_r, ptr_r} <= {VALID_I,
				{3{VALID_I}} & {we_nxt, trap_nxt, ptr_nxt}};
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			{res_r, vec_r, flags_r} <= {WORD_RST, VEC_ILLEGAL, FLAGS_RST};
		else if (VALID_I)
			{res_r, vec_r, flags_r} <= {res_nxt, vec_nxt, flags_nxt};
	end

	// software write loses to any issued operation in the same cycle
	always_ff @(posedge REF_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			q_r <= WORD_RST;
		else if (VALID_I)
			q_r <= q_nxt;
		else if (QUOTIENT_WE_I)
			q_r <= SPR_DATA_I;
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			funnel_r <= FUNNEL_RST;
		else if (FUNNEL_WE_I)
			funnel_r <= SPR_DATA_I[4:0];
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			{pa_r, pb_r, pc_r} <= 24'h000000;
		else if (VALID_I && is_emu)
			{pa_r, pb_r, pc_r} <= {FIRST_REG_NUM_I, SECOND_REG_NUM_I,
			                       RESULT_REG_NUM_I};
	end

	assign DONE_O               = done_r;
	assign RESULT_REGISTER_O    = res_r;
	assign RESULT_WE_O          = we_r;
	assign TRAP_O               = trap_r;
	assign TRAP_VECTOR_O        = vec_r;
	assign PTR_LOAD_O           = ptr_r;
	assign PTR_FIRST_O          = pa_r;
	assign PTR_SECOND_O         = pb_r;
	assign PTR_RESULT_O         = pc_r;
	assign FLAGS_O              = flags_r;
	assign FUNNEL_SHIFT_COUNT_O = funnel_r;
	assign QUOTIENT_EXT_O       = q_r;

endmodule : iae_execute

`default_nettype wire

// >>> pkg/iae_pkg.sv
// iae_pkg: opcodes, field positions, trap vectors and constants for the
// integer execute datapath.
// assumes an 8-bit operation code decoded upstream into this local map.
package iae_pkg;

	localparam int          DATA_W     = 32;
	localparam int          OPC_W      = 8;
	localparam int          IMM_W      = 8;
	localparam int          VEC_W      = 8;
	localparam int          REGN_W     = 8;
	localparam int          SHAMT_W    = 5;

	// arithmetic family: op[7:5]=000, op[4:3] kind, op[2] carry, op[1:0] check
	localparam logic [2:0]  ARITH_GRP  = 3'h0;
	localparam int          ARITH_MSB  = 7;
	localparam int          ARITH_LSB  = 5;
	localparam int          KIND_MSB   = 4;
	localparam int          KIND_LSB   = 3;
	localparam int          CARRY_BIT  = 2;
	localparam int          CHK_MSB    = 1;
	localparam int          CHK_LSB    = 0;
	localparam logic [1:0]  KIND_ADD   = 2'h0;
	localparam logic [1:0]  KIND_SUB   = 2'h1;
	localparam logic [1:0]  KIND_RSUB  = 2'h2;
	localparam logic [1:0]  CHK_NONE   = 2'h0;
	localparam logic [1:0]  CHK_SIGNED = 2'h1;
	localparam logic [1:0]  CHK_UNSIGN = 2'h2;

	// compare families: low nibble selects the condition
	localparam logic [3:0]  CMP_GRP    = 4'h2;
	localparam logic [3:0]  ASSERT_GRP = 4'h3;
	localparam logic [3:0]  CND_EQ     = 4'h0;
	localparam logic [3:0]  CND_NEQ    = 4'h1;
	localparam logic [3:0]  CND_LT     = 4'h2;
	localparam logic [3:0]  CND_LTU    = 4'h3;
	localparam logic [3:0]  CND_LE     = 4'h4;
	localparam logic [3:0]  CND_LEU    = 4'h5;
	localparam logic [3:0]  CND_GT     = 4'h6;
	localparam logic [3:0]  CND_GTU    = 4'h7;
	localparam logic [3:0]  CND_GE     = 4'h8;
	localparam logic [3:0]  CND_GEU    = 4'h9;
	localparam logic [3:0]  CND_BYTE   = 4'hA;

	localparam logic [7:0]  OP_AND     = 8'h40;
	localparam logic [7:0]  OP_ANDC    = 8'h41;
	localparam logic [7:0]  OP_NAND    = 8'h42;
	localparam logic [7:0]  OP_OR      = 8'h43;
	localparam logic [7:0]  OP_NOR     = 8'h44;
	localparam logic [7:0]  OP_XOR     = 8'h45;
	localparam logic [7:0]  OP_XNOR    = 8'h46;
	localparam logic [7:0]  OP_SHL     = 8'h48;
	localparam logic [7:0]  OP_SHR     = 8'h49;
	localparam logic [7:0]  OP_SHRA    = 8'h4A;
	localparam logic [7:0]  OP_FUNNEL  = 8'h4B;
	localparam logic [7:0]  OP_PLO_U   = 8'h50;
	localparam logic [7:0]  OP_PLO_S   = 8'h51;
	localparam logic [7:0]  OP_PHI_S   = 8'h52;
	localparam logic [7:0]  OP_PHI_U   = 8'h53;
	localparam logic [7:0]  OP_PSTEP_S = 8'h54;
	localparam logic [7:0]  OP_PSTEP_U = 8'h55;
	localparam logic [7:0]  OP_PFINAL  = 8'h56;
	localparam logic [7:0]  OP_QUO_U   = 8'h58;
	localparam logic [7:0]  OP_QUO_S   = 8'h59;
	localparam logic [7:0]  OP_QINIT   = 8'h5A;
	localparam logic [7:0]  OP_QSTEP   = 8'h5B;
	localparam logic [7:0]  OP_QFINAL  = 8'h5C;
	localparam logic [7:0]  OP_QREM    = 8'h5D;

	// emulation opcodes; vector is the opcode minus 0xC0
	localparam logic [7:0]  EMU_A_LO   = 8'hD8;
	localparam logic [7:0]  EMU_A_HI   = 8'hDD;
	localparam logic [7:0]  EMU_B_LO   = 8'hE7;
	localparam logic [7:0]  EMU_B_HI   = 8'hE9;
	localparam logic [7:0]  EMU_C      = 8'hF8;
	localparam logic [7:0]  EMU_D_LO   = 8'hFA;
	localparam logic [7:0]  EMU_OFFSET = 8'hC0;

	localparam logic [7:0]  VEC_ILLEGAL = 8'h00;
	localparam logic [7:0]  VEC_RANGE   = 8'h02;
	localparam logic [7:0]  VEC_PROTECT = 8'h05;
	localparam logic [7:0]  VEC_PROD    = 8'h20;
	localparam logic [7:0]  VEC_QUO     = 8'h22;
	localparam logic [7:0]  VEC_USR_MAX = 8'h3F;

	localparam logic [31:0] BOOL_TRUE  = 32'h80000000;
	localparam logic [31:0] BOOL_FALSE = 32'h00000000;
	localparam logic [3:0]  FLAGS_RST  = 4'h0;
	localparam logic [4:0]  FUNNEL_RST = 5'h00;
	localparam logic [31:0] WORD_RST   = 32'h00000000;

endpackage : iae_pkg

// >>> verif/iae_execute_properties.sv
// iae_execute_properties: port-level checker for the execute datapath.
// assumes one clock domain and the active-low asynchronous core reset.
`timescale 1ns/1ps
`default_nettype none
module iae_execute_chk
	import iae_pkg::*;
(
	input  wire logic        REF_CLK_I,
	input  wire logic        NRST_I,
	input  wire logic        VALID_I,
	input  wire logic [7:0]  OPCODE_I,
	input  wire logic [31:0] FIRST_OPERAND_I,
	input  wire logic [31:0] SECOND_OPERAND_I,
	input  wire logic        IMM_SEL_I,
	input  wire logic [7:0]  TRAP_VECTOR_NUMBER_I,
	input  wire logic        USER_MODE_I,
	input  wire logic        FUNNEL_WE_I,
	input  wire logic [31:0] SPR_DATA_I,
	input  wire logic        DONE_O,
	input  wire logic [31:0] RESULT_REGISTER_O,
	input  wire logic        RESULT_WE_O,
	input  wire logic        TRAP_O,
	input  wire logic [7:0]  TRAP_VECTOR_O,
	input  wire logic        PTR_LOAD_O,
	input  wire logic [3:0]  FLAGS_O,
	input  wire logic [4:0]  FUNNEL_SHIFT_COUNT_O
);
	// slices kept as nets so that $past sees plain signals
	wire logic [4:0] sh_w = SECOND_OPERAND_I[4:0];
	wire logic [4:0] fc_w = SPR_DATA_I[4:0];
	wire logic       as_w = VALID_I && OPCODE_I[7:4] == ASSERT_GRP
		&& OPCODE_I[3:0] <= CND_GEU;

	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!NRST_I);

	property p_issue;
		VALID_I |=> DONE_O;
	endproperty
	a_issue: assert property (p_issue) else $error("done late");
	property p_idle;
		!VALID_I |=> !DONE_O && !RESULT_WE_O && !TRAP_O;
	endproperty
	a_idle: assert property (p_idle) else $error("pulse w/o issue");
	property p_emu;
		VALID_I && OPCODE_I inside {[8'hD8:8'hDD], [8'hE7:8'hE9], 8'hF8,
			[8'hFA:8'hFF]} |=> TRAP_O && PTR_LOAD_O && !RESULT_WE_O
			&& TRAP_VECTOR_O == $past(OPCODE_I) - EMU_OFFSET;
	endproperty
	a_emu: assert property (p_emu) else $error("emulation trap");
	property p_illegal;
		VALID_I && OPCODE_I[7:5] == ARITH_GRP && (OPCODE_I[4:3] == 2'h3
			|| OPCODE_I[1:0] == 2'h3) |=> TRAP_O && !RESULT_WE_O
			&& TRAP_VECTOR_O == VEC_ILLEGAL && $stable(FLAGS_O);
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal");
	property p_bool;
		VALID_I && OPCODE_I[7:4] == CMP_GRP && OPCODE_I[3:0] <= CND_BYTE
			|=> RESULT_WE_O && RESULT_REGISTER_O[30:0] == 31'h0
			&& $stable(FLAGS_O);
	endproperty
	a_bool: assert property (p_bool) else $error("boolean form");
	property p_protect;
		as_w && USER_MODE_I && TRAP_VECTOR_NUMBER_I <= VEC_USR_MAX
			|=> !RESULT_WE_O && (!TRAP_O || TRAP_VECTOR_O == VEC_PROTECT);
	endproperty
	a_protect: assert property (p_protect) else $error("user vec");
	property p_vec;
		as_w && !USER_MODE_I
			|=> !TRAP_O || TRAP_VECTOR_O == $past(TRAP_VECTOR_NUMBER_I);
	endproperty
	a_vec: assert property (p_vec) else $error("assert vector");
	property p_shift;
		VALID_I && OPCODE_I == OP_SHL && !IMM_SEL_I |=> RESULT_REGISTER_O
			== ($past(FIRST_OPERAND_I) << $past(sh_w));
	endproperty
	a_shift: assert property (p_shift) else $error("left shift");
	property p_logic;
		VALID_I && OPCODE_I == OP_XOR && !IMM_SEL_I |=> RESULT_REGISTER_O
			== ($past(FIRST_OPERAND_I) ^ $past(SECOND_OPERAND_I));
	endproperty
	a_logic: assert property (p_logic) else $error("xor result");
	property p_funnel;
		FUNNEL_WE_I && !VALID_I |=> FUNNEL_SHIFT_COUNT_O == $past(fc_w);
	endproperty
	a_funnel: assert property (p_funnel) else $error("funnel cnt");
endmodule : iae_execute_chk

bind iae_execute iae_execute_chk u_chk (
	.REF_CLK_I, .NRST_I, .VALID_I, .OPCODE_I, .FIRST_OPERAND_I,
	.SECOND_OPERAND_I, .IMM_SEL_I, .TRAP_VECTOR_NUMBER_I, .USER_MODE_I,
	.FUNNEL_WE_I, .SPR_DATA_I, .DONE_O, .RESULT_REGISTER_O, .RESULT_WE_O,
	.TRAP_O, .TRAP_VECTOR_O, .PTR_LOAD_O, .FLAGS_O, .FUNNEL_SHIFT_COUNT_O
);
`default_nettype wire

// >>> verif/iae_execute_tb.sv
// iae_execute_tb: random self-checking bench against a behavioural model.
// assumes results one cycle after each issue; steps chain through Q.
`timescale 1ns/1ps
`default_nettype none
module iae_execute_tb;
	import iae_pkg::*;
	logic        clk, nrst, vld, isel, usr, fwe, qwe;
	logic [7:0]  opc, imm, vn, ra, rb, rc;
	logic [31:0] a, b, spr;
	logic        done, we, trap, pld;
	logic [31:0] res, qx;
	logic [7:0]  tvec, pf, ps, pr;
	logic [3:0]  flg;
	logic [4:0]  fcnt;
	logic [3:0]  mf;
	logic [31:0] mq, e_r;
	logic [4:0]  mfc;
	logic        e_d, e_we, e_tr, e_pl;
	logic [7:0]  e_v, e_pf, e_ps, e_pr;
	int          error_cnt;
	int          total_checks;
	logic [7:0]  pq [13] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55,
		8'h56, 8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h5D};

	iae_execute #(.HAS_MULT(1'b1)) u_dut (
		.REF_CLK_I(clk), .NRST_I(nrst), .VALID_I(vld), .OPCODE_I(opc),
		.FIRST_OPERAND_I(a), .SECOND_OPERAND_I(b), .IMM_I(imm),
		.IMM_SEL_I(isel), .TRAP_VECTOR_NUMBER_I(vn), .USER_MODE_I(usr),
		.FIRST_REG_NUM_I(ra), .SECOND_REG_NUM_I(rb), .RESULT_REG_NUM_I(rc),
		.FUNNEL_WE_I(fwe), .QUOTIENT_WE_I(qwe), .SPR_DATA_I(spr),
		.DONE_O(done), .RESULT_REGISTER_O(res), .RESULT_WE_O(we),
		.TRAP_O(trap), .TRAP_VECTOR_O(tvec), .PTR_LOAD_O(pld),
		.PTR_FIRST_O(pf), .PTR_SECOND_O(ps), .PTR_RESULT_O(pr),
		.FLAGS_O(flg), .FUNNEL_SHIFT_COUNT_O(fcnt), .QUOTIENT_EXT_O(qx)
	);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (e !== g)
		begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic rst();
		nrst <= 1'b0;
		vld  <= 1'b0;
		fwe  <= 1'b0;
		qwe  <= 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		{mf, mq, mfc, e_d} = '0;
	endtask : rst

	task automatic drive();
		logic [31:0] ta;
		logic [7:0]  t;
		logic        v;
		ta = $urandom;
		// boundary words make the overflow and borrow traps common
		if ($urandom_range(0, 3) == 0)
			ta = {$urandom_range(0, 1) == 1, 31'h7FFFFFFF};
		case ($urandom_range(0, 5))
			0: t = 8'($urandom_range(0, 31));
			1: t = 8'h20 + 8'($urandom_range(0, 15));
			2: t = 8'h30 + 8'($urandom_range(0, 15));
			3: t = 8'h40 + 8'($urandom_range(0, 11));
			4: t = pq[$urandom_range(0, 12)];
			default: t = 8'hC0 + 8'($urandom_range(0, 63));
		endcase
		v = $urandom_range(0, 7) != 0;
		vld  <= v;
		opc  <= t;
		a    <= ta;
		b    <= ($urandom_range(0, 3) == 0) ? ta : $urandom;
		imm  <= 8'($urandom);
		isel <= $urandom_range(0, 3) == 0;
		vn   <= 8'($urandom_range(0, 127));
		usr  <= $urandom_range(0, 1) == 1;
		{ra, rb, rc} <= 24'($urandom);
		spr  <= $urandom;
		// software writes only in idle slots: an issue would win over the quotient write
		fwe  <= !v && $urandom_range(0, 1) == 1;
		qwe  <= !v && $urandom_range(0, 1) == 1;
	endtask : drive

	task automatic model();
		logic [32:0] s;
		logic [63:0] p;
		logic [63:0] f;
		logic [31:0] x;
		logic [31:0] y;
		logic        ok;
		logic        nz;
		logic        ad;
		x = a;
		y = isel ? {24'h0, imm} : b;
		f = {x, y} << mfc;
		ok = 1'b0;
		nz = 1'b1;
		ad = opc[4:3] == KIND_ADD;
		{e_d, e_we, e_tr, e_pl, e_v, e_r} = {vld, 3'h0, VEC_ILLEGAL, 32'h0};
		{e_pf, e_ps, e_pr} = {ra, rb, rc};
		if (!vld)
		begin
			nz = 1'b0;
			if (fwe) mfc = spr[4:0];
			if (qwe) mq = spr;
		end
		else if (opc[7:5] == ARITH_GRP)
		begin
			nz = 1'b0;
			if (opc[4:3] == KIND_RSUB) {x, y} = {y, x};
			if (!ad) y = ~y;
			s = {1'b0, x} + {1'b0, y} + 33'(opc[CARRY_BIT] ? mf[0] : !ad);
			e_r = s[31:0];
			ok = x[31] == y[31] && e_r[31] != x[31];
			if (opc[4:3] == 2'h3 || opc[1:0] == 2'h3) e_tr = 1'b1;
			else
			begin
				e_we = 1'b1;
				mf = {ok, e_r[31], e_r == 32'h0, s[32]};
				e_v = VEC_RANGE;
				e_tr = opc[1:0] == CHK_SIGNED ? ok :
					opc[1:0] == CHK_UNSIGN && s[32] == ad;
			end
		end
		else if (opc[7:5] == 3'h1 && opc[3:0] <= (opc[4] ? CND_GEU : CND_BYTE))
		begin
			case (opc[3:0])
				CND_EQ:  ok = x == y;
				CND_NEQ: ok = x != y;
				CND_LT:  ok = $signed(x) < $signed(y);
				CND_LTU: ok = x < y;
				CND_LE:  ok = $signed(x) <= $signed(y);
				CND_LEU: ok = x <= y;
				CND_GT:  ok = $signed(x) > $signed(y);
				CND_GTU: ok = x > y;
				CND_GE:  ok = $signed(x) >= $signed(y);
				CND_GEU: ok = x >= y;
				default: ok = x[7:0] == y[7:0] || x[15:8] == y[15:8]
					|| x[23:16] == y[23:16] || x[31:24] == y[31:24];
			endcase
			nz = 1'b0;
			e_we = !opc[4];
			e_r = ok ? BOOL_TRUE : BOOL_FALSE;
			e_tr = opc[4] && !ok;
			e_v = usr && vn <= VEC_USR_MAX ? VEC_PROTECT : vn;
		end
		else if (opc inside {[OP_AND:OP_XNOR], [OP_SHL:OP_FUNNEL]})
			case (opc)
				OP_AND:  e_r = x & y;
				OP_ANDC: e_r = x & ~y;
				OP_NAND: e_r = ~(x & y);
				OP_OR:   e_r = x | y;
				OP_NOR:  e_r = ~(x | y);
				OP_XOR:  e_r = x ^ y;
				OP_XNOR: e_r = ~(x ^ y);
				OP_SHL:  e_r = x << y[4:0];
				OP_SHR:  e_r = x >> y[4:0];
				OP_SHRA: e_r = $signed(x) >>> y[4:0];
				default: e_r = f[63:32];
			endcase
		else if (opc inside {[OP_PLO_U:OP_PHI_U]})
		begin
			p = (opc == OP_PLO_S || opc == OP_PHI_S) ?
				{{32{x[31]}}, x} * {{32{y[31]}}, y} : {32'h0, x} * {32'h0, y};
			e_r = opc[1] ? p[63:32] : p[31:0];
		end
		else if (opc inside {[OP_PSTEP_S:OP_PFINAL]})
		begin
			// multiplier bits leave Q at its low end, product bits enter high
			s = {opc != OP_PSTEP_U && x[31], x};
			if (mq[0])
				s = opc == OP_PFINAL ? s - {y[31], y}
					: s + {opc == OP_PSTEP_S && y[31], y};
			{e_r, mq} = {s, mq[31:1]};
		end
		else if (opc == OP_QSTEP || opc == OP_QFINAL)
		begin
			// restoring step: partial remainder in first operand
			s = {x, mq[31]};
			ok = s >= {1'b0, y};
			if (ok) s = s - {1'b0, y};
			{e_r, mq} = {s[31:0], mq[30:0], ok};
		end
		else if (opc == OP_QUO_U || opc == OP_QUO_S)
			{nz, e_tr, e_v} = {2'b01, VEC_QUO};
		else if (opc == OP_QINIT)
			mq = y;
		else if (opc == OP_QREM)
			e_r = x;
		else if (opc inside {[EMU_A_LO:EMU_A_HI], [EMU_B_LO:EMU_B_HI], EMU_C,
			[EMU_D_LO:8'hFF]})
			{nz, e_tr, e_pl, e_v} = {3'b011, opc - EMU_OFFSET};
		else
			{nz, e_tr} = 2'b01;
		if (nz) e_we = 1'b1;
		if (nz) mf[2:1] = {e_r[31], e_r == 32'h0};
	endtask : model

	task automatic check();
		chk("done", e_d, done);
		chk("funnel count", mfc, fcnt);
		chk("quotient ext", mq, qx);
		chk("flags", mf, flg);
		if (e_d)
		begin
			chk("write", e_we, we);
			chk("trap", e_tr, trap);
			chk("ptr load", e_pl, pld);
			if (e_tr) chk("vector", e_v, tvec);
			if (e_we) chk("result", e_r, res);
			if (e_pl) chk("ptrs", {e_pf, e_ps, e_pr}, {pf, ps, pr});
		end
	endtask : check

	initial
	begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		end_sim();
	end

	initial
	begin
		void'($urandom(32'h4559));
		{nrst, vld, isel, usr, fwe, qwe} = '0;
		{opc, imm, vn, ra, rb, rc, a, b, spr} = '0;
		{error_cnt, total_checks} = '0;
		rst();
		repeat (2)
		begin
			repeat (600)
			begin
				@(posedge clk);
				drive();
				#1;
				check();
				model();
			end
			rst();
		end
		end_sim();
	end
endmodule : iae_execute_tb
`default_nettype wire
